// File: design/tesc_cfg.svh
// Register offsets, field positions and reset values for the trace enable block
`ifndef TESC_CFG_SVH
`define TESC_CFG_SVH
// Register byte offsets within the 4 KB window
`define TESC_OFF_CR      12'h000
`define TESC_OFF_TRIG    12'h008
`define TESC_OFF_SR      12'h010
`define TESC_OFF_TEEV    12'h020
`define TESC_OFF_TEC1    12'h024
`define TESC_OFF_SSSEL   12'h1F0
`define TESC_OFF_TRID    12'h200
// Reset values
`define TESC_RST_CR      32'h0000_0411
`define TESC_RST_EVENT   17'h0_0000
`define TESC_RST_ZERO    32'h0000_0000
// Main control fields
`define TESC_CR_PWRDN    0
`define TESC_CR_PROG     10
// Trace enable control 1: start/stop qualifier
`define TESC_TEC1_SSEN   25
// Status fields
`define TESC_SR_PROG     1
`define TESC_SR_SSTATE   2
`define TESC_SR_TRIG     3
// Start/stop select: start sources low, stop sources high
`define TESC_SS_START    0
`define TESC_SS_STOP     16
// Resource types
`define TESC_RT_WPT      3'h2
`define TESC_RT_CNT      3'h4
`define TESC_RT_SS       3'h5
`define TESC_RT_EXT      3'h6
`define TESC_IDX_SS      4'hF
`define TESC_IDX_TRUE    4'hF
// Event value that is always true
`define TESC_EV_ALWAYS   17'h0_006F
// Marker word placed in the stream on a trigger
`define TESC_TRIG_MARK   32'h0000_000C
`define TESC_ATB_4BYTES  2'h3
`endif

// File: design/tesc_pkg.sv
// Types shared by the trace enable block
package tesc_pkg;
  // One event definition: function, resource B, resource A
  typedef struct packed {
    logic [2:0] func;
    logic [6:0] res_b;
    logic [6:0] res_a;
  } tesc_event_t;
  // Live resources offered to the event logic
  typedef struct packed {
    logic       startstop;
    logic [1:0] ext;
    logic [3:0] wpt;
  } tesc_res_t;
  // Start/stop state
  typedef enum logic [1:0] {
    TESC_STOP  = 2'b01,
    TESC_START = 2'b10
  } tesc_ss_t;
endpackage

// File: design/tesc_event_eval.sv
// Event evaluator: two resources combined by a boolean function
`timescale 1ns/1ps
`include "tesc_cfg.svh"
module tesc_event_eval (
  // Event definition
  input  wire tesc_pkg::tesc_event_t ev,
  // Live resources
  input  wire tesc_pkg::tesc_res_t   res,
  // Result
  output logic                       hit
);
  logic a;  // Resource A value
  logic b;  // Resource B value

  // Look up one resource; unknown codes read false
  function automatic logic pick(input logic [6:0] r,
                                input tesc_pkg::tesc_res_t rs);
    logic v;
    v = 1'b0;
    case (r[6:4])
      `TESC_RT_WPT: v = (r[3:2] == 2'h0) ? rs.wpt[r[1:0]] : 1'b0;
      `TESC_RT_SS:  v = (r[3:0] == `TESC_IDX_SS) & rs.startstop;
      `TESC_RT_EXT: begin
        if (r[3:0] == `TESC_IDX_TRUE) begin
          v = 1'b1;
        end else if (r[3:1] == 3'h0) begin
          v = rs.ext[r[0]];
        end
      end
      // Counter resource is not built here, reads false
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // Field split and function table
  always_comb begin
    a = pick(ev.res_a, res);
    b = pick(ev.res_b, res);
    case (ev.func)
      3'h0: hit = a;
      3'h1: hit = ~a;
      3'h2: hit = a & b;
      3'h3: hit = ~a & b;
      3'h4: hit = ~a & ~b;
      3'h5: hit = a | b;
      3'h6: hit = ~a | b;
      3'h7: hit = ~a | ~b;
      default: hit = 1'b0;
    endcase
  end
endmodule

// File: design/tesc_top.sv
// Trace enable, start/stop and trigger control with AHB-Lite registers
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "tesc_cfg.svh"
module tesc_top #(
  parameter int NWPT = 4, // Watchpoint comparator inputs
  parameter int NEXT = 2  // External trigger inputs
) (
  // Clock, reset, enable
  input  wire  logic            hclk,
  input  wire  logic            hresetn,
  input  wire  logic            ce,
  // AHB-Lite slave
  input  wire  logic            hsel,
  input  wire  logic [31:0]     haddr,
  input  wire  logic [1:0]      htrans,
  input  wire  logic            hwrite,
  input  wire  logic [2:0]      hsize,
  input  wire  logic [31:0]     hwdata,
  input  wire  logic            hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Trigger and watchpoint inputs
  input  wire  logic [NEXT-1:0] ext_trigger_in,
  input  wire  logic [NWPT-1:0] watchpoint_comparator_inputs,
  // Trace words from the core side
  input  wire  logic            trace_in_valid,
  input  wire  logic [31:0]     trace_in_data,
  output logic                  trace_in_ready,
  // ATB master
  output logic                  atvalid,
  output logic [31:0]           atdata,
  output logic [1:0]            atbytes,
  output logic [6:0]            atid,
  input  wire  logic            atready,
  // Trigger and state outputs
  output logic                  macrocell_trigger_out,
  output logic                  trace_active
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Registers
  logic [31:0]           ctrl;                           // Main control
  tesc_pkg::tesc_event_t trigger_event;                  // Trigger event
  tesc_pkg::tesc_event_t trace_enable_event_reg;         // Enable event
  logic [31:0]           trace_enable_control_1;         // Start/stop qualifier
  logic [31:0]           startstop_source_select;        // Start/stop sources
  logic [6:0]            trace_id;                       // ATB source id
  logic                  trig_flag;                      // Trigger seen, sticky

  // Bus data-phase state
  logic                  wr_pend;  // Write in data phase
  logic [11:0]           wr_addr;  // Its offset
  logic                  rd_take;  // Read accepted now
  logic                  wr_take;  // Write accepted now
  logic [31:0]           next_rdata;

  // Input synchronisers and edges
  logic [NWPT-1:0]       wpt_m;    // First stage only
  logic [NWPT-1:0]       wpt_s;    // Second stage
  logic [NWPT-1:0]       wpt_d;    // One cycle older
  logic [NEXT-1:0]       ext_m;
  logic [NEXT-1:0]       ext_s;
  logic [NWPT-1:0]       start_hit;
  logic [NWPT-1:0]       stop_hit;

  // Start/stop and event results
  tesc_pkg::tesc_ss_t    ss_state;
  tesc_pkg::tesc_res_t   res;
  logic                  started;
  logic                  te_hit;
  logic                  trig_hit;
  logic                  trace_on;

  // Trigger and stream control
  logic                  trig_done; // Trigger fired once
  logic                  trig_pend; // Marker waiting for slot
  logic                  slot_free;
  logic                  take_word;
  logic                  next_atvalid;
  logic                  next_trig_pend;

  // Bus handshake decode
  always_comb begin
    rd_take = hsel & hready & htrans[1] & ~hwrite;
    wr_take = hsel & hready & htrans[1] & hwrite;
  end

  // Zero wait, always OKAY; kept in flops so outputs are registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (ce) begin
      // Frozen with everything else while the enable is low
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address capture for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (ce) begin
      wr_pend <= wr_take;
      wr_addr <= haddr[11:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = `TESC_RST_ZERO;
    case (haddr[11:0])
      `TESC_OFF_CR:    next_rdata = ctrl;
      `TESC_OFF_TRIG:  next_rdata[16:0] = trigger_event;
      `TESC_OFF_SR: begin
        next_rdata[`TESC_SR_PROG]   = ctrl[`TESC_CR_PROG];
        next_rdata[`TESC_SR_SSTATE] = started;
        next_rdata[`TESC_SR_TRIG]   = trig_flag;
      end
      `TESC_OFF_TEEV:  next_rdata[16:0] = trace_enable_event_reg;
      `TESC_OFF_TEC1:  next_rdata = trace_enable_control_1;
      `TESC_OFF_SSSEL: next_rdata = startstop_source_select;
      `TESC_OFF_TRID:  next_rdata[6:0] = trace_id;
      default:         next_rdata = `TESC_RST_ZERO;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `TESC_RST_ZERO;
    end else if (ce && rd_take) begin
      hrdata <= next_rdata;
    end
  end

  // Control and event registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                    <= `TESC_RST_CR;
      trigger_event           <= `TESC_RST_EVENT;
      trace_enable_event_reg  <= `TESC_RST_EVENT;
      trace_enable_control_1  <= `TESC_RST_ZERO;
      startstop_source_select <= `TESC_RST_ZERO;
      trace_id                <= 7'h00;
    end else if (ce && wr_pend) begin
      case (wr_addr)
        `TESC_OFF_CR:    ctrl <= hwdata;
        `TESC_OFF_TRIG:  trigger_event <= hwdata[16:0];
        `TESC_OFF_TEEV:  trace_enable_event_reg <= hwdata[16:0];
        `TESC_OFF_TEC1:  trace_enable_control_1 <= hwdata;
        `TESC_OFF_SSSEL: startstop_source_select <= hwdata;
        `TESC_OFF_TRID:  trace_id <= hwdata[6:0];
        // Status writes only reach the trigger flag clear below; unmapped writes are ignored
        default: ;
      endcase
    end
  end

  // Two-flop synchronisers for watchpoint and external inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpt_m <= '0;
      wpt_s <= '0;
      wpt_d <= '0;
      ext_m <= '0;
      ext_s <= '0;
    end else if (ce) begin
      wpt_m <= watchpoint_comparator_inputs;
      wpt_s <= wpt_m;
      wpt_d <= wpt_s;
      ext_m <= ext_trigger_in;
      ext_s <= ext_m;
    end
  end

  // Per-comparator start and stop edges
  for (genvar i = 0; i < NWPT; i++) begin : g_edge
    always_comb begin
      // Rise of a start source, fall of a stop source
      start_hit[i] = wpt_s[i] & ~wpt_d[i]
                     & startstop_source_select[`TESC_SS_START + i];
      stop_hit[i]  = ~wpt_s[i] & wpt_d[i]
                     & startstop_source_select[`TESC_SS_STOP + i];
    end
  end

  // Start/stop state; only watchpoint edges move it, stop wins a tie
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_state <= tesc_pkg::TESC_STOP;
    end else if (ce) begin
      case (ss_state)
        tesc_pkg::TESC_STOP: begin
          if (|start_hit && !(|stop_hit)) begin
            ss_state <= tesc_pkg::TESC_START;
          end
        end
        tesc_pkg::TESC_START: begin
          if (|stop_hit) begin
            ss_state <= tesc_pkg::TESC_STOP;
          end
        end
        default: ss_state <= tesc_pkg::TESC_STOP;
      endcase
    end
  end

  // Resource bundle shared by both events
  always_comb begin
    started       = (ss_state == tesc_pkg::TESC_START);
    res.startstop = started;
    res.ext       = ext_s;
    res.wpt       = wpt_s;
  end

  // Trace enable event
  tesc_event_eval u_te_eval (
    .ev  (trace_enable_event_reg),
    .res (res),
    .hit (te_hit)
  );

  // Trigger event
  tesc_event_eval u_trig_eval (
    .ev  (trigger_event),
    .res (res),
    .hit (trig_hit)
  );

  // Tracing gate; powered down or programming blocks it
  always_comb begin
    trace_on = te_hit
               & (~trace_enable_control_1[`TESC_TEC1_SSEN] | started)
               & ~ctrl[`TESC_CR_PROG] & ~ctrl[`TESC_CR_PWRDN];
  end

  // One trigger per run; rearmed by entering programming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_done             <= 1'b0;
      macrocell_trigger_out <= 1'b0;
    end else if (ce) begin
      macrocell_trigger_out <= 1'b0;
      if (ctrl[`TESC_CR_PROG]) begin
        trig_done <= 1'b0;
      end else if (trig_hit && !trig_done) begin
        trig_done             <= 1'b1;
        macrocell_trigger_out <= 1'b1;
      end
    end
  end

  // Sticky trigger status; a new trigger beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_flag <= 1'b0;
    end else if (ce) begin
      if (trig_hit && !trig_done && !ctrl[`TESC_CR_PROG]) begin
        trig_flag <= 1'b1;
      end else if (wr_pend && wr_addr == `TESC_OFF_SR
                   && !hwdata[`TESC_SR_TRIG]) begin
        trig_flag <= 1'b0;
      end
    end
  end

  // Stream slot arbitration: marker first, words wait
  always_comb begin
    slot_free      = ~atvalid | atready;
    take_word      = trace_in_valid & trace_in_ready & slot_free & ~trig_pend;
    next_trig_pend = trig_pend;
    if (trig_pend && slot_free) begin
      next_trig_pend = 1'b0;
    end
    if (trig_hit && !trig_done && !ctrl[`TESC_CR_PROG]) begin
      next_trig_pend = 1'b1;
    end
    next_atvalid = atvalid & ~atready;
    if (trig_pend && slot_free) begin
      next_atvalid = 1'b1;
    end else if (take_word && trace_on) begin
      next_atvalid = 1'b1;
    end
  end

  // ATB output register; a stalled beat holds still
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      atvalid        <= 1'b0;
      atdata         <= `TESC_RST_ZERO;
      atbytes        <= `TESC_ATB_4BYTES;
      atid           <= 7'h00;
      trig_pend      <= 1'b0;
      trace_in_ready <= 1'b0;
    end else if (ce) begin
      atvalid   <= next_atvalid;
      trig_pend <= next_trig_pend;
      // Ready only when the slot is sure to be free next cycle
      trace_in_ready <= ~next_atvalid & ~next_trig_pend;
      if (trig_pend && slot_free) begin
        atdata <= `TESC_TRIG_MARK;
        atid   <= trace_id;
      end else if (take_word && trace_on) begin
        atdata <= trace_in_data;
        atid   <= trace_id;
      end
      atbytes <= `TESC_ATB_4BYTES;
    end
  end

  // Tracing state seen outside
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_active <= 1'b0;
    end else if (ce) begin
      trace_active <= trace_on;
    end
  end

  // Checks
  a_start_rise: assert property (ce && |start_hit && !(|stop_hit) |=> started)
    else $error("start edge did not start");
  a_stop_fall: assert property (ce && |stop_hit |=> !started)
    else $error("stop edge did not stop");
  a_ss_only_wpt: assert property (ce && !(|start_hit) && !(|stop_hit)
                                  |=> $stable(started))
    else $error("start/stop moved without an edge");
  a_gate_ssen: assert property (ce && take_word && !started
      && trace_enable_control_1[`TESC_TEC1_SSEN] && !atvalid |=> !atvalid)
    else $error("word traced while stopped");
  a_event_gate: assert property (ce && take_word && !te_hit && !atvalid
                                 && !trig_pend |=> !atvalid)
    else $error("word traced with event false");
  a_always_true: assert property (trace_enable_event_reg == `TESC_EV_ALWAYS
                                  |-> te_hit)
    else $error("always-true event not true");
  a_trig_marker: assert property (ce && macrocell_trigger_out |-> trig_pend)
    else $error("trigger without pending marker");
  a_trig_pulse: assert property (macrocell_trigger_out |=> !macrocell_trigger_out)
    else $error("trigger output longer than one cycle");
  a_atb_hold: assert property (atvalid && !atready
                               |=> atvalid && $stable(atdata))
    else $error("ATB beat dropped while stalled");
  a_bus_okay: assert property ($past(hresetn) && $past(ce) |-> hreadyout && !hresp)
    else $error("bus answer not ready OKAY");
endmodule

// File: dv/tesc_atb_sink.sv
// ATB sink model standing in for the trace funnel on the far side
`timescale 1ns/1ps
module tesc_atb_sink (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Stall request from the bench
  input  wire logic        stall,
  // ATB slave side
  input  wire logic        atvalid,
  input  wire logic [31:0] atdata,
  input  wire logic [1:0]  atbytes,
  output logic             atready,
  // Capture results
  output logic [7:0]       beats,
  output logic [31:0]      last
);
  // Ready follows stall one cycle late, as a busy funnel would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      atready <= 1'b0;
    end else begin
      atready <= !stall;
    end
  end
  // Beat taken only on valid and ready at the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beats <= 8'h00;
      last  <= 32'h0000_0000;
    end else if (atvalid && atready) begin
      beats <= beats + 8'h01;
      last  <= atdata;
    end
  end
endmodule

// File: dv/tesc_top_tb.sv
// Self-checking bench for the trace enable and trigger block
`timescale 1ns/1ps
`include "tesc_cfg.svh"
module tesc_top_tb;
  // Bench-driven inputs
  logic        hclk, hresetn, hwrite, trace_in_valid, stall;
  logic [1:0]  htrans, ext;
  logic [3:0]  wpt;
  logic [31:0] haddr, hwdata, trace_in_data, rd;
  // Design outputs
  logic        hreadyout, hresp, trace_in_ready, atvalid, atready, trig_out, active;
  logic [31:0] hrdata, atdata, last;
  logic [1:0]  atbytes;
  logic [6:0]  atid;
  logic [7:0]  beats, b0;
  // Cross-trigger partner lines
  logic [7:0]  xtrig_in, xtrig_out;
  // Scoreboard
  int          failures, comparisons, cycles;

  tesc_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_trigger_in(ext),
    .watchpoint_comparator_inputs(wpt), .trace_in_valid(trace_in_valid),
    .trace_in_data(trace_in_data), .trace_in_ready(trace_in_ready), .atvalid(atvalid),
    .atdata(atdata), .atbytes(atbytes), .atid(atid), .atready(atready),
    .macrocell_trigger_out(trig_out), .trace_active(active));
  tesc_atb_sink sink (.hclk(hclk), .hresetn(hresetn), .stall(stall), .atvalid(atvalid),
    .atdata(atdata), .atbytes(atbytes), .atready(atready), .beats(beats), .last(last));

  // Cross-trigger partner with the default wiring; optional in a system
  always_comb begin
    xtrig_in       = 8'h00;       // No trace buffer: bits 3,2 idle
    xtrig_in[7]    = trig_out;
    xtrig_in[6:4]  = wpt[2:0];    // Watchpoint trigger lines
    xtrig_out      = 8'h00;       // No interrupt lines here
    xtrig_out[5:4] = ext;         // Bench levels stand for outputs 5,4
    xtrig_out[0]   = xtrig_in[7]; // Trigger routed to the halt request
  end

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Hang guard, well above the expected run
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One AHB-Lite single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  // Program under the prog bit, then release it so changes land together
  task automatic cfg(input logic [31:0] tr, ev, c1, sel);
    wr(`TESC_OFF_CR, 32'h0000_0400);
    wr(`TESC_OFF_TRIG, tr);
    wr(`TESC_OFF_TEEV, ev);
    wr(`TESC_OFF_TEC1, c1);
    wr(`TESC_OFF_SSSEL, sel);
    wr(`TESC_OFF_CR, 32'h0000_0000);
    wait_n(8);
  endtask
  // Offer one trace word; held until ready is seen
  task automatic send(input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    trace_in_valid <= 1'b1;
    trace_in_data  <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (trace_in_ready !== 1'b1 && n < 50);
    trace_in_valid <= 1'b0;
  endtask

  task automatic t_reset();
    rdr(`TESC_OFF_CR, rd);
    chk("ctrl", 32'h0000_0411, rd);
    rdr(`TESC_OFF_TRID, rd);
    chk("trace id", 32'h0000_0000, rd);
    rdr(12'h100, rd);
    chk("unmapped", 32'h0000_0000, rd);
    chk("active", 32'h0, {31'h0, active});
    rdr(`TESC_OFF_SR, rd);
    chk("ss reset", 32'h0, {31'h0, rd[`TESC_SR_SSTATE]});
    $display("test reset done");
  endtask
  // Always-true event lets words through; a stalled sink holds the beat
  task automatic t_always();
    cfg(32'h0, 32'h0000_006F, 32'h0, 32'h0);
    chk("active", 32'h1, {31'h0, active});
    wr(`TESC_OFF_TRID, 32'h0000_0015);
    b0 = beats;
    stall <= 1'b1;
    send(32'hA5A5_0001);
    wait_n(4);
    chk("atvalid", 32'h1, {31'h0, atvalid});
    chk("atdata", 32'hA5A5_0001, atdata);
    chk("atbytes", 32'h3, {30'h0, atbytes});
    chk("atid", 32'h0000_0015, {25'h0, atid});
    stall <= 1'b0;
    wait_n(4);
    chk("beats", {24'h0, b0 + 8'h01}, {24'h0, beats});
    chk("last", 32'hA5A5_0001, last);
    cfg(32'h0, 32'h0, 32'h0, 32'h0);
    b0 = beats;
    send(32'h5A5A_0002);
    wait_n(6);
    chk("dropped", {24'h0, b0}, {24'h0, beats});
    $display("test always done");
  endtask
  // Every function code over every pair of external input levels
  task automatic t_funcs();
    logic [2:0] f;
    logic       a, b, e;
    for (int k = 0; k < 32; k++) begin
      f = k[4:2];
      a = k[0];
      b = k[1];
      ext <= {b, a};
      cfg(32'h0, {15'h0, f, 7'h61, 7'h60}, 32'h0, 32'h0);
      case (f)
        3'd0: e = a;
        3'd1: e = !a;
        3'd2: e = a & b;
        3'd3: e = !a & b;
        3'd4: e = !a & !b;
        3'd5: e = a | b;
        3'd6: e = !a | b;
        default: e = !a | !b;
      endcase
      chk("func gate", {31'h0, e}, {31'h0, active});
    end
    $display("test funcs done");
  endtask
  // Start on wpt0 rising, stop on wpt1 falling, qualified by bit 25
  task automatic t_startstop();
    ext <= 2'b00;
    cfg(32'h0, 32'h0000_006F, 32'h0200_0000, 32'h0002_0001);
    chk("ss idle", 32'h0, {31'h0, active});
    b0 = beats;
    send(32'h0BAD_0003);
    wait_n(4);
    chk("ss drop", {24'h0, b0}, {24'h0, beats});
    wpt <= 4'b0110;
    ext <= 2'b11;
    wait_n(8);
    chk("ss other", 32'h0, {31'h0, active});
    wpt <= 4'b0111;
    wait_n(8);
    chk("ss start", 32'h1, {31'h0, active});
    rdr(`TESC_OFF_SR, rd);
    chk("ss bit", 32'h1, {31'h0, rd[`TESC_SR_SSTATE]});
    // Start/stop resource AND watchpoint 2 as the enable event
    cfg(32'h0, 32'h0000_915F, 32'h0200_0000, 32'h0002_0001);
    chk("ss resource", 32'h1, {31'h0, active});
    wpt <= 4'b0110;
    wait_n(8);
    chk("ss hold", 32'h1, {31'h0, active});
    wpt <= 4'b0100;
    wait_n(8);
    chk("ss stop", 32'h0, {31'h0, active});
    wpt <= 4'b0110;
    wait_n(8);
    wpt <= 4'b0101;
    wait_n(8);
    chk("ss both", 32'h0, {31'h0, active});
    rdr(`TESC_OFF_SR, rd);
    chk("ss bit", 32'h0, {31'h0, rd[`TESC_SR_SSTATE]});
    $display("test startstop done");
  endtask
  // Trigger on ext0: one pulse, marker in stream, gate untouched
  task automatic t_trigger();
    int n;
    ext <= 2'b00;
    wpt <= 4'b0000;
    cfg(32'h0000_0060, 32'h0000_006F, 32'h0, 32'h0);
    b0 = beats;
    ext <= 2'b01;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (trig_out !== 1'b1 && n < 40);
    chk("trig seen", 32'h1, {31'h0, trig_out});
    chk("halt req", 32'h1, {31'h0, xtrig_out[0]});
    @(posedge hclk);
    chk("trig pulse", 32'h0, {31'h0, trig_out});
    wait_n(6);
    chk("marker count", {24'h0, b0 + 8'h01}, {24'h0, beats});
    chk("marker", `TESC_TRIG_MARK, last);
    chk("trig gate", 32'h1, {31'h0, active});
    rdr(`TESC_OFF_SR, rd);
    chk("trig flag", 32'h1, {31'h0, rd[`TESC_SR_TRIG]});
    $display("test trigger done");
  endtask

  initial begin
    hresetn = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    trace_in_valid = 1'b0;
    trace_in_data = 32'h0000_0000;
    stall = 1'b0;
    ext = 2'b00;
    wpt = 4'h0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_always();
    t_funcs();
    t_startstop();
    t_trigger();
    conclude();
  end
endmodule
